// ===== sim/loop_det_channel_asserts.sv
`timescale 1ns/1ps
module loop_det_channel_chk
    import loop_det_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
    parameter int DELTA_W     = 16
) (
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    input  wire logic [DELTA_W-1:0] loop_delta_i,
    input  wire logic               inhibit_i,
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    input  wire logic [31:0]        avs_readdata,
    input  wire logic               avs_waitrequest,
    input  wire logic               det_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    localparam int REL_CYC = 50 * TICK_CYCLES;
    localparam int PW_MIN  = 100 * TICK_CYCLES;
    localparam int PW_MAX  = 150 * TICK_CYCLES;

    ctrl_t ctrl_q;
    int    hi_run_q;
    int    zero_run_q;
    int    big_run_q;
    wire   ctrl_wr = avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_byteenable[0];
    wire   no_ext  = ctrl_q.mode == MODE_PRESENCE && ctrl_q.de_mode != DE_EXTEND;
    wire   plain   = no_ext && ctrl_q.de_mode != DE_DELAY;
    wire   pulse_n = ctrl_q.mode == MODE_PULSE && ctrl_q.de_mode != DE_DELAY
                     && ctrl_q.de_mode != DE_EXTEND;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q     <= '0;
            hi_run_q   <= 0;
            zero_run_q <= 0;
            big_run_q  <= 0;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= ctrl_t'(avs_writedata[4:0]);
            end
            hi_run_q   <= det_o ? hi_run_q + 1 : 0;
            zero_run_q <= (loop_delta_i == '0) ? zero_run_q + 1 : 0;
            big_run_q  <= (loop_delta_i >= THR3_RST) ? big_run_q + 1 : 0;
        end
    end

    wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("waitrequest low without request");
    rdata_hold_a: assert property (!((avs_read || avs_write) && avs_waitrequest)
        |=> $stable(avs_readdata))
        else $error("readdata changed without read");
    pulse_width_a: assert property ($fell(det_o) && pulse_n
        |-> hi_run_q >= PW_MIN && hi_run_q <= PW_MAX)
        else $error("pulse width out of range");
    presence_release_a: assert property (no_ext && zero_run_q == REL_CYC |-> !det_o)
        else $error("output not released after loop cleared");
    presence_assert_a: assert property (plain && big_run_q == REL_CYC |-> det_o)
        else $error("output not raised for large step");
    presence_cause_a: assert property ($rose(det_o) && ctrl_q.mode == MODE_PRESENCE
        |-> zero_run_q < TICK_CYCLES)
        else $error("output raised with empty loop");

    cover property (pulse_n && $fell(det_o));
    cover property (no_ext && zero_run_q == REL_CYC);
    cover property ($rose(det_o) && ctrl_q.de_mode == DE_EXTEND);
endmodule : loop_det_channel_chk

bind loop_det_channel loop_det_channel_chk #(
    .TICK_CYCLES(TICK_CYCLES),
    .DELTA_W    (DELTA_W)
) chk_u (
    .ref_clk_i      (ref_clk_i),
    .arst_n_i       (arst_n_i),
    .loop_delta_i   (loop_delta_i),
    .inhibit_i      (inhibit_i),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .det_o          (det_o)
);

// ===== sim/loop_front_model.sv
`timescale 1ns/1ps
module loop_front_model
    import loop_det_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [15:0] delta_req_i,
    input  wire logic        inh_req_i,
    input  wire logic        det_i,
    output logic [15:0]      loop_delta_o,
    output logic             inhibit_o,
    output int               pulses_o
);
    logic det_q;

    // Front end refreshes its measurement every cycle; controller counts detections
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loop_delta_o <= 16'h0;
            inhibit_o    <= 1'b0;
            det_q        <= 1'b0;
            pulses_o     <= 0;
        end else begin
            loop_delta_o <= delta_req_i;
            inhibit_o    <= inh_req_i;
            det_q        <= det_i;
            if (det_i && !det_q) begin
                pulses_o <= pulses_o + 1;
            end
        end
    end
endmodule : loop_front_model

// ===== sim/test_vehicle_loop_detector_channel.sv
`timescale 1ns/1ps
module test_vehicle_loop_detector_channel
    import loop_det_pkg::*;
;
    localparam int TC = 10;
    logic        ref_clk_i;
    logic        arst_n_i;
    logic [15:0] delta_req;
    logic        inh_req;
    logic [15:0] loop_delta;
    logic        inhibit;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        det_o;
    int          pulses;
    int          mismatches;
    int          num_checks;
    int          took;
    int          base;
    logic [31:0] rd;
    logic [15:0] thr_tab [4] = '{THR0_RST, THR1_RST, THR2_RST, THR3_RST};

    loop_det_channel #(.TICK_CYCLES(TC), .DELTA_W(16)) dut_u (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .loop_delta_i(loop_delta),
        .inhibit_i(inhibit), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .det_o(det_o)
    );

    loop_front_model front_u (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .delta_req_i(delta_req),
        .inh_req_i(inh_req), .det_i(det_o), .loop_delta_o(loop_delta),
        .inhibit_o(inhibit), .pulses_o(pulses)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check_eq

    task automatic ok(input logic c);
        check_eq({31'h0, c}, 32'h1);
    endtask : ok

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        ok(n < 50);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
    endtask : wr_reg

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        check_eq(rd, exp);
    endtask : rd_chk

    task automatic ticks(input int n);
        repeat (n * TC) @(posedge ref_clk_i);
    endtask : ticks

    task automatic wait_det(input logic v, input int lim);
        took = 0;
        do begin
            @(posedge ref_clk_i);
            took++;
        end while (det_o !== v && took < lim);
    endtask : wait_det

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (95000) @(posedge ref_clk_i);
        mismatches++;
        close_out();
    end

    initial begin
        arst_n_i = 1'b0; delta_req = 16'h0; inh_req = 1'b0; avs_address = 5'h00;
        avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0; avs_byteenable = 4'h0;
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        // Reset values, read-only status, empty lanes, hole in the map
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_DE_TIME, 32'h0);
        rd_chk(OFS_FILTER, 32'h2);
        for (int i = 0; i < 4; i++) rd_chk(OFS_THR0 + 5'(4 * i), {16'h0, thr_tab[i]});
        wr_reg(OFS_STATUS, 32'h1f, 4'hf);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
        check_eq({30'h0, rd[1:0]}, 32'h0);
        wr_reg(OFS_FILTER, 32'h7, 4'h0);
        rd_chk(OFS_FILTER, 32'h2);
        rd_chk(5'h11, 32'h0);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            wr_reg(OFS_CTRL, 32'(s << 1), 4'h1);
            delta_req <= thr_tab[s] - 16'h1;
            ticks(10);
            ok(det_o === 1'b0);
            delta_req <= thr_tab[s];
            wait_det(1'b1, 125 * TC);
            ok(took < (s == 3 ? 50 : 125) * TC);
            delta_req <= 16'h0;
            wait_det(1'b0, 125 * TC);
            ok(took < (s == 3 ? 50 : 125) * TC);
        end
        $display("test sensitivity done");
        wr_reg(OFS_CTRL, 32'h0, 4'h1);
        delta_req <= THR3_RST;
        wait_det(1'b1, 50 * TC);
        ticks(2000);
        ok(det_o === 1'b1);
        delta_req <= 16'h0;
        wait_det(1'b0, 1000 * TC);
        ok(took < 1000 * TC);
        delta_req <= THR0_RST;
        wait_det(1'b1, 125 * TC);
        ok(took < 125 * TC);
        delta_req <= 16'h0;
        wait_det(1'b0, 125 * TC);
        $display("test presence done");
        wr_reg(OFS_CTRL, 32'h1, 4'h1);
        base = pulses;
        delta_req <= 16'h0064;
        wait_det(1'b1, 125 * TC);
        wait_det(1'b0, 200 * TC);
        ok(took >= 100 * TC && took <= 150 * TC);
        ticks(300);
        ok(pulses == base + 1);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
        ok(rd[3] === 1'b0);
        delta_req <= 16'h0;
        ticks(20);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
        ok(rd[3] === 1'b1);
        delta_req <= 16'h0064;
        ticks(2900);
        delta_req <= 16'h00c8;
        wait_det(1'b1, 100 * TC);
        ok(took < 100 * TC);
        wait_det(1'b0, 200 * TC);
        ok(pulses == base + 3);
        delta_req <= 16'h0;
        ticks(20);
        $display("test pulse done");
        wr_reg(OFS_DE_TIME, 32'd50, 4'h3);
        wr_reg(OFS_CTRL, 32'h08, 4'h1);
        delta_req <= 16'h0064;
        ticks(40);
        ok(det_o === 1'b0);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
        ok(rd[4] === 1'b1);
        wait_det(1'b1, 30 * TC);
        ok(took < 30 * TC);
        delta_req <= 16'h0;
        wait_det(1'b0, 20 * TC);
        base = pulses;
        delta_req <= 16'h0064;
        ticks(20);
        delta_req <= 16'h0;
        ticks(60);
        ok(pulses == base);
        inh_req <= 1'b1;
        ticks(5);
        inh_req <= 1'b0;
        ticks(30);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
        ok(rd[2] === 1'b0);
        inh_req <= 1'b1;
        ticks(40);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hf);
        ok(rd[2] === 1'b1);
        delta_req <= 16'h0064;
        wait_det(1'b1, 100 * TC);
        ok(took < 10 * TC);
        delta_req <= 16'h0;
        wait_det(1'b0, 20 * TC);
        inh_req <= 1'b0;
        ticks(40);
        $display("test delay done");
        wr_reg(OFS_CTRL, 32'h10, 4'h1);
        delta_req <= 16'h0064;
        wait_det(1'b1, 20 * TC);
        delta_req <= 16'h0;
        ticks(20);
        ok(det_o === 1'b1);
        delta_req <= 16'h0064;
        ticks(10);
        delta_req <= 16'h0;
        ticks(40);
        ok(det_o === 1'b1);
        wait_det(1'b0, 30 * TC);
        ok(took < 30 * TC);
        $display("test extension done");
        close_out();
    end
endmodule : test_vehicle_loop_detector_channel

// ===== src/loop_det_channel.sv
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module loop_det_channel
    import loop_det_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
    parameter int DELTA_W     = 16
) (
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    // Loop front end measurement, same clock domain
    input  wire logic [DELTA_W-1:0] loop_delta_i,
    // Timing suppress pin, active high when on
    input  wire logic               inhibit_i,
    // Avalon-MM slave
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // Detection output to the signal controller
    output logic                    det_o
);

    typedef enum logic [1:0] {
        P_IDLE  = 2'b00,
        P_PULSE = 2'b01,
        P_HELD  = 2'b10,
        P_WAIT  = 2'b11
    } pulse_state_t;

    typedef enum logic [1:0] {
        D_OFF   = 2'b00,
        D_DELAY = 2'b01,
        D_ON    = 2'b10,
        D_EXT   = 2'b11
    } de_state_t;

    logic                tick;
    logic                inhibit;
    ctrl_t               ctrl_q;
    logic [14:0]         de_time_q;
    logic [7:0]          filter_q;
    logic [15:0]         thr_q [4];
    logic                occ_q;
    logic [7:0]          flt_cnt_q;
    logic [DELTA_W-1:0]  base_q;
    pulse_state_t        p_state_q, p_state_d;
    logic [11:0]         p_cnt_q, p_cnt_d;
    de_state_t           de_state_q, de_state_d;
    logic [14:0]         de_cnt_q, de_cnt_d;
    status_t             status;

    tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .tick_o    (tick)
    );

    suppress_qual u_qual (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .tick_i    (tick),
        .pin_i     (inhibit_i),
        .level_o   (inhibit)
    );

    // Bus slave: one wait cycle, then the answer
    wire        req     = avs_read || avs_write;
    wire        done    = req && !avs_waitrequest;
    wire        wr_en   = done && avs_write;
    wire        sel_ctl = (avs_address == OFS_CTRL);
    wire        sel_det = (avs_address == OFS_DE_TIME);
    wire        sel_flt = (avs_address == OFS_FILTER);
    wire        sel_sts = (avs_address == OFS_STATUS);
    wire        sel_thr = (avs_address[4] == OFS_THR0[4]) && (avs_address[1:0] == 2'b00);
    wire [1:0]  thr_idx = avs_address[3:2];

    assign status.detect      = det_o;
    assign status.occupied    = occ_q;
    assign status.inhibit     = inhibit;
    assign status.pulse_armed = (p_state_q == P_IDLE);
    assign status.de_busy     = (de_state_q == D_DELAY) || (de_state_q == D_EXT);

    wire [31:0] rd_mux = sel_ctl ? {27'h0, ctrl_q} :
                         sel_det ? {17'h0, de_time_q} :
                         sel_flt ? {24'h0, filter_q} :
                         sel_sts ? {27'h0, status} :
                         sel_thr ? {16'h0, thr_q[thr_idx]} : 32'h0;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (req && avs_waitrequest) begin
                avs_readdata <= avs_read ? rd_mux : 32'h0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q    <= '{de_mode: DE_NORMAL, sens_sel: 2'b00, mode: MODE_PRESENCE};
            de_time_q <= DE_TIME_RST;
            filter_q  <= FILTER_RST;
        end else begin
            if (wr_en && sel_ctl && avs_byteenable[0]) begin
                ctrl_q <= ctrl_t'(avs_writedata[4:0]);
            end
            if (wr_en && sel_det && avs_byteenable[0]) begin
                de_time_q[7:0] <= avs_writedata[7:0];
            end
            if (wr_en && sel_det && avs_byteenable[1]) begin
                de_time_q[14:8] <= avs_writedata[14:8];
            end
            if (wr_en && sel_flt && avs_byteenable[0]) begin
                filter_q <= avs_writedata[7:0];
            end
        end
    end

    // Threshold table, one register per sensitivity selection
    localparam logic [15:0] THR_RST [4] = '{THR0_RST, THR1_RST, THR2_RST, THR3_RST};
    for (genvar i = 0; i < 4; i++) begin : g_thr
        wire wr_lo = wr_en && sel_thr && (thr_idx == 2'(i)) && avs_byteenable[0];
        wire wr_hi = wr_en && sel_thr && (thr_idx == 2'(i)) && avs_byteenable[1];
        always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                thr_q[i] <= THR_RST[i];
            end else begin
                if (wr_lo) begin
                    thr_q[i][7:0] <= avs_writedata[7:0];
                end
                if (wr_hi) begin
                    thr_q[i][15:8] <= avs_writedata[15:8];
                end
            end
        end
    end

    // Occupancy: change above re-armed baseline versus selected threshold
    wire [DELTA_W-1:0] thr_sel = DELTA_W'(thr_q[ctrl_q.sens_sel]);
    wire [DELTA_W-1:0] rel     = (loop_delta_i >= base_q) ? loop_delta_i - base_q
                                                          : '0;
    wire               raw_occ = (rel >= thr_sel);
    wire               flt_hit = (9'(flt_cnt_q) + 9'h1 >= 9'(filter_q));

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            occ_q     <= 1'b0;
            flt_cnt_q <= 8'h0;
        end else if (tick) begin
            if (raw_occ == occ_q) begin
                flt_cnt_q <= 8'h0;
            end else if (flt_hit) begin
                occ_q     <= raw_occ;
                flt_cnt_q <= 8'h0;
            end else begin
                flt_cnt_q <= flt_cnt_q + 8'h1;
            end
        end
    end

    // Pulse mode sequencer
    wire pulse_mode = (ctrl_q.mode == MODE_PULSE);
    wire rearm      = (p_state_q == P_HELD) && tick && occ_q
                   && (p_cnt_q + 12'h1 >= 12'(REARM_TICKS));

    always_comb begin
        p_state_d = p_state_q;
        p_cnt_d   = p_cnt_q;
        unique case (p_state_q)
            P_IDLE: begin
                p_cnt_d = 12'h0;
                if (occ_q && pulse_mode) begin
                    p_state_d = P_PULSE;
                end
            end
            P_PULSE: begin
                if (tick) begin
                    p_cnt_d = p_cnt_q + 12'h1;
                end
                if (tick && p_cnt_q + 12'h1 >= 12'(PULSE_TICKS)) begin
                    p_state_d = P_HELD;
                    p_cnt_d   = 12'h0;
                end
            end
            P_HELD: begin
                if (!occ_q) begin
                    p_state_d = P_IDLE;
                end else if (rearm) begin
                    p_state_d = P_WAIT;
                end else if (tick) begin
                    p_cnt_d = p_cnt_q + 12'h1;
                end
            end
            P_WAIT: begin
                p_cnt_d = 12'h0;
                if (!occ_q) begin
                    p_state_d = P_IDLE;
                end
            end
        endcase
        if (!pulse_mode) begin
            p_state_d = P_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            p_state_q <= P_IDLE;
            p_cnt_q   <= 12'h0;
            base_q    <= '0;
        end else begin
            p_state_q <= p_state_d;
            p_cnt_q   <= p_cnt_d;
            if (!pulse_mode || loop_delta_i < thr_sel) begin
                base_q <= '0;
            end else if (rearm) begin
                base_q <= loop_delta_i;
            end
        end
    end

    // Delay and extension stage
    wire src    = pulse_mode ? (p_state_q == P_PULSE) : occ_q;
    wire bypass = inhibit || (de_time_q == 15'h0)
               || (ctrl_q.de_mode != DE_DELAY && ctrl_q.de_mode != DE_EXTEND);
    wire de_hit = (de_cnt_q + 15'h1 >= de_time_q);

    always_comb begin
        de_state_d = de_state_q;
        de_cnt_d   = de_cnt_q;
        unique case (de_state_q)
            D_OFF: begin
                de_cnt_d = 15'h0;
                if (src) begin
                    de_state_d = (!bypass && ctrl_q.de_mode == DE_DELAY) ? D_DELAY : D_ON;
                end
            end
            D_DELAY: begin
                if (!src) begin
                    de_state_d = D_OFF;
                    de_cnt_d   = 15'h0;
                end else if (bypass) begin
                    de_state_d = D_ON;
                end else if (tick && de_hit) begin
                    de_state_d = D_ON;
                end else if (tick) begin
                    de_cnt_d = de_cnt_q + 15'h1;
                end
            end
            D_ON: begin
                de_cnt_d = 15'h0;
                if (!src) begin
                    de_state_d = (!bypass && ctrl_q.de_mode == DE_EXTEND) ? D_EXT : D_OFF;
                end
            end
            D_EXT: begin
                if (src) begin
                    de_state_d = D_ON;
                    de_cnt_d   = 15'h0;
                end else if (bypass) begin
                    de_state_d = D_OFF;
                end else if (tick && de_hit) begin
                    de_state_d = D_OFF;
                end else if (tick) begin
                    de_cnt_d = de_cnt_q + 15'h1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            de_state_q <= D_OFF;
            de_cnt_q   <= 15'h0;
            det_o      <= 1'b0;
        end else begin
            de_state_q <= de_state_d;
            de_cnt_q   <= de_cnt_d;
            det_o      <= (de_state_d == D_ON) || (de_state_d == D_EXT);
        end
    end

endmodule : loop_det_channel

// ===== src/loop_det_pkg.sv
package loop_det_pkg;

    localparam int CLK_PERIOD_NS    = 10;
    localparam int TICK_PERIOD_US   = 1000;
    localparam int TICK_CYCLES_DFLT = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // Suppress input qualification, in microseconds, then in ticks
    localparam int IGNORE_TIME_US   = 8300;
    localparam int ACCEPT_TIME_US   = 333000;
    localparam int DWELL_TIME_US    = 20000;
    localparam int SPACE_MIN_US     = 16600;
    localparam int SPACE_TIME_US    = 17000;
    localparam int DWELL_TICKS      = (DWELL_TIME_US + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
    localparam int SPACE_TICKS      = (SPACE_TIME_US + TICK_PERIOD_US - 1) / TICK_PERIOD_US;

    // Pulse mode timing
    localparam int PULSE_TIME_MS    = 125;
    localparam int REARM_TIME_MS    = 2000;
    localparam int PULSE_TICKS      = PULSE_TIME_MS * 1000 / TICK_PERIOD_US;
    localparam int REARM_TICKS      = REARM_TIME_MS * 1000 / TICK_PERIOD_US;

    // Register byte offsets
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_DE_TIME = 5'h04;
    localparam logic [4:0] OFS_FILTER  = 5'h08;
    localparam logic [4:0] OFS_STATUS  = 5'h0c;
    localparam logic [4:0] OFS_THR0    = 5'h10;

    // Control field positions
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_SENS_LSB  = 1;
    localparam int CTRL_DE_LSB    = 3;

    // Reset values; thresholds in units of 0.01 percent of loop inductance
    localparam logic [15:0] THR0_RST    = 16'h000d;
    localparam logic [15:0] THR1_RST    = 16'h0020;
    localparam logic [15:0] THR2_RST    = 16'h0064;
    localparam logic [15:0] THR3_RST    = 16'h0140;
    localparam logic [14:0] DE_TIME_RST = 15'h0000;
    localparam logic [7:0]  FILTER_RST  = 8'h02;

    typedef enum logic {
        MODE_PRESENCE = 1'b0,
        MODE_PULSE    = 1'b1
    } out_mode_t;

    typedef enum logic [1:0] {
        DE_NORMAL = 2'b00,
        DE_DELAY  = 2'b01,
        DE_EXTEND = 2'b10
    } de_mode_t;

    typedef struct packed {
        de_mode_t  de_mode;
        logic [1:0] sens_sel;
        out_mode_t mode;
    } ctrl_t;

    typedef struct packed {
        logic de_busy;
        logic pulse_armed;
        logic inhibit;
        logic occupied;
        logic detect;
    } status_t;

endpackage : loop_det_pkg

// ===== src/suppress_qual.sv
`timescale 1ns/1ps
module suppress_qual
    import loop_det_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic arst_n_i,
    input  wire logic tick_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic       s1_q, s2_q, s3_q;
    logic [9:0] dwell_q;
    logic [9:0] since_rise_q;
    logic [9:0] since_fall_q;

    wire agree    = (s2_q == s3_q);
    wire differs  = agree && (s3_q != level_o);
    wire dwell_ok = (dwell_q + 10'h1 >= 10'(DWELL_TICKS));
    wire space_ok = s3_q ? (since_rise_q >= 10'(SPACE_TICKS))
                         : (since_fall_q >= 10'(SPACE_TICKS));
    wire accept   = tick_i && differs && dwell_ok && space_ok;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dwell_q      <= 10'h0;
            since_rise_q <= 10'h3ff;
            since_fall_q <= 10'h3ff;
            level_o      <= 1'b0;
        end else begin
            if (agree && !differs) begin
                dwell_q <= 10'h0;
            end else if (tick_i && differs && !dwell_ok) begin
                dwell_q <= dwell_q + 10'h1;
            end
            if (accept) begin
                level_o <= s3_q;
                dwell_q <= 10'h0;
            end
            if (accept && s3_q) begin
                since_rise_q <= 10'h0;
            end else if (tick_i && since_rise_q != 10'h3ff) begin
                since_rise_q <= since_rise_q + 10'h1;
            end
            if (accept && !s3_q) begin
                since_fall_q <= 10'h0;
            end else if (tick_i && since_fall_q != 10'h3ff) begin
                since_fall_q <= since_fall_q + 10'h1;
            end
        end
    end
endmodule : suppress_qual

// ===== src/tick_gen.sv
`timescale 1ns/1ps
module tick_gen
    import loop_det_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input  wire logic ref_clk_i,
    input  wire logic arst_n_i,
    output logic      tick_o
);
    logic [31:0] cnt_q;
    wire         wrap = (cnt_q == 32'(TICK_CYCLES - 1));

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= 32'h0;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= wrap ? 32'h0 : cnt_q + 32'h1;
            tick_o <= wrap;
        end
    end
endmodule : tick_gen
